// [hw/sdpwr_mem.sv]
// dram end: command decode and clock-enable power state tracking
// Behaviour
// - inputs sampled only at link clock rise
// - mode load captures address as opcode
// - refresh row from internal counter
// - self-refresh ignores all but clock enable and the command at exit
// - controller activates only idle banks
// - controller reads/writes only active banks
// - burst stop only for full page
// - legality follows bank selected by bank_select_line
// - idle plus clock enable low: power-down
// - idle, enable low, refresh pins: self-refresh
// - other-bank activate waits row_to_row_delay
// - precharge waits min_row_active_time
// - autoclose precharges bank after burst, unless a burst stop cuts it short
// - self-refresh exit with nop, idle after row cycle
// - recovery plus enable low: power-down next
// - power-down holds while low, exits rising
// - non-idle enable toggles suspend/resume next cycle
// - idle decode: activate, refresh, mode load
// - wakes on clock enable rising
`timescale 1ns/1ps
`default_nettype none
module sdpwr_mem (
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    sdpwr_link_if.mem                  link,
    output logic                       cmd_valid,
    output sdpwr_pkg::sdpwr_cmd_t      cmd,
    output sdpwr_pkg::sdpwr_mode_t     mode,
    output logic [1:0]                 bank_open,
    output logic [11:0]                opcode,
    output logic [10:0]                refresh_row,
    output logic                       illegal
);
    import sdpwr_pkg::*;

    logic [17:0] pins_s;
    sdpwr_sync #(.W(18)) u_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in ({link.link_clk, link.clk_en, link.chip_sel_n, link.row_strobe_n,
                    link.col_strobe_n, link.write_en_n, link.addr}),
        .sync_out (pins_s)
    );

    typedef struct packed {
        logic        clk_prev;
        logic        cke_prev;
        sdpwr_mode_t mode;
        logic [1:0]  open;
        logic [1:0]  autoclose;
        logic [3:0]  burst_cnt0;
        logic [3:0]  burst_cnt1;
        logic [3:0]  rrd_cnt;
        logic [3:0]  ras_cnt0;
        logic [3:0]  ras_cnt1;
        logic [3:0]  wait_cnt;
        logic        full_page;
        logic [11:0] opcode;
        logic [10:0] row_cnt;
        logic        cmd_valid;
        sdpwr_cmd_t  cmd;
        logic        illegal;
    } sdpwr_mem_st_t;

    sdpwr_mem_st_t st;
    sdpwr_mem_st_t next_st;

    logic       rise;
    logic       cke;
    logic       cs_n, ras_n, cas_n, we_n;
    logic [11:0] a;
    logic       bank;
    logic       nop_like;
    sdpwr_cmd_t dec;

    always_comb begin
        cke   = pins_s[16];
        cs_n  = pins_s[15];
        ras_n = pins_s[14];
        cas_n = pins_s[13];
        we_n  = pins_s[12];
        a     = pins_s[ADDR_W-1:0];
        bank  = a[BANK_SEL_BIT];
        rise  = pins_s[17] & ~st.clk_prev;
        nop_like = cs_n | (ras_n & cas_n);
        dec = SDPWR_CMD_DESELECT;
        if (!cs_n) begin
            unique case ({ras_n, cas_n, we_n})
                3'b111: dec = SDPWR_CMD_NOP;
                3'b110: dec = SDPWR_CMD_BURST_STOP;
                3'b101: dec = a[10] ? SDPWR_CMD_READ_AUTOCLOSE : SDPWR_CMD_READ;
                3'b100: dec = a[10] ? SDPWR_CMD_WRITE_AUTOCLOSE : SDPWR_CMD_WRITE;
                3'b011: dec = SDPWR_CMD_ROW_ACTIVATE;
                3'b010: dec = SDPWR_CMD_PRECHARGE;
                3'b001: dec = SDPWR_CMD_REFRESH;
                3'b000: dec = SDPWR_CMD_MODE_LOAD;
            endcase
        end
    end

    always_comb begin
        next_st           = st;
        next_st.clk_prev  = pins_s[17];
        next_st.cmd_valid = 1'b0;
        next_st.illegal   = 1'b0;
        if (rise) begin
            next_st.cke_prev = cke;
            if (st.rrd_cnt != CNT_ZERO) next_st.rrd_cnt = st.rrd_cnt - 4'h1;
            if (st.ras_cnt0 != CNT_ZERO) next_st.ras_cnt0 = st.ras_cnt0 - 4'h1;
            if (st.ras_cnt1 != CNT_ZERO) next_st.ras_cnt1 = st.ras_cnt1 - 4'h1;
            if (st.wait_cnt != CNT_ZERO) next_st.wait_cnt = st.wait_cnt - 4'h1;
            // autoclose bursts close their bank once the count runs out; a burst stop leaves the bank open
            if (st.burst_cnt0 != CNT_ZERO && st.mode != SDPWR_M_SUSPEND) begin
                next_st.burst_cnt0 = st.burst_cnt0 - 4'h1;
                if (st.burst_cnt0 == 4'h1 && st.autoclose[0]) begin
                    next_st.open[0] = 1'b0;
                    next_st.autoclose[0] = 1'b0;
                end
            end
            if (st.burst_cnt1 != CNT_ZERO && st.mode != SDPWR_M_SUSPEND) begin
                next_st.burst_cnt1 = st.burst_cnt1 - 4'h1;
                if (st.burst_cnt1 == 4'h1 && st.autoclose[1]) begin
                    next_st.open[1] = 1'b0;
                    next_st.autoclose[1] = 1'b0;
                end
            end
            unique case (st.mode)
                SDPWR_M_SELF_REFRESH: begin
                    // commands are ignored here except on the clock enable rise, where anything but a deselect, no-op or burst stop is illegal
                    if (!st.cke_prev && cke) begin
                        next_st.illegal = ~nop_like;
                        next_st.mode = SDPWR_M_SR_RECOVERY;
                        next_st.wait_cnt = 4'(RC_CYC);
                    end
                end
                SDPWR_M_SR_RECOVERY: begin
                    if (!nop_like) next_st.illegal = 1'b1;
                    else if (!cke) next_st.mode = SDPWR_M_POWER_DOWN;
                    else if (st.wait_cnt <= 4'h1) next_st.mode = SDPWR_M_IDLE;
                end
                SDPWR_M_POWER_DOWN: begin
                    if (cke) next_st.mode = SDPWR_M_IDLE;
                end
                SDPWR_M_SUSPEND: begin
                    if (cke) next_st.mode = SDPWR_M_ACTIVE;
                end
                SDPWR_M_IDLE, SDPWR_M_ACTIVE: begin
                    if (st.cke_prev && !cke) begin
                        if (st.open == 2'b00 && dec == SDPWR_CMD_REFRESH) begin
                            next_st.mode = SDPWR_M_SELF_REFRESH;
                        end else if (st.open == 2'b00) begin
                            next_st.mode = SDPWR_M_POWER_DOWN;
                        end else begin
                            next_st.mode = SDPWR_M_SUSPEND;
                        end
                    end else if (cke && st.wait_cnt <= 4'h1) begin
                        // spans are loaded whole, so a count of one runs out at this rise
                        next_st.cmd_valid = (dec != SDPWR_CMD_DESELECT);
                        next_st.cmd = dec;
                        unique case (dec)
                            SDPWR_CMD_ROW_ACTIVATE: begin
                                // legality by the bank that bank_select_line picks
                                if (st.open[bank] || st.rrd_cnt > 4'h1) begin
                                    next_st.illegal = 1'b1;
                                end else begin
                                    next_st.open[bank] = 1'b1;
                                    next_st.rrd_cnt = 4'(RRD_CYC);
                                    if (bank) next_st.ras_cnt1 = 4'(RAS_CYC);
                                    else next_st.ras_cnt0 = 4'(RAS_CYC);
                                end
                            end
                            SDPWR_CMD_PRECHARGE: begin
                                if ((a[10] || !bank) && st.open[0] && st.ras_cnt0 > 4'h1)
                                    next_st.illegal = 1'b1;
                                else if ((a[10] || bank) && st.open[1] && st.ras_cnt1 > 4'h1)
                                    next_st.illegal = 1'b1;
                                else if (a[10]) next_st.open = 2'b00;
                                else next_st.open[bank] = 1'b0;
                            end
                            SDPWR_CMD_READ, SDPWR_CMD_READ_AUTOCLOSE,
                            SDPWR_CMD_WRITE, SDPWR_CMD_WRITE_AUTOCLOSE: begin
                                if (!st.open[bank]) next_st.illegal = 1'b1;
                                else begin
                                    next_st.autoclose[bank] = (dec == SDPWR_CMD_READ_AUTOCLOSE)
                                        || (dec == SDPWR_CMD_WRITE_AUTOCLOSE);
                                    if (bank) next_st.burst_cnt1 = 4'(BURST_CYCLES);
                                    else next_st.burst_cnt0 = 4'(BURST_CYCLES);
                                end
                            end
                            SDPWR_CMD_BURST_STOP: begin
                                if (st.full_page) begin
                                    next_st.burst_cnt0 = CNT_ZERO;
                                    next_st.burst_cnt1 = CNT_ZERO;
                                end
                            end
                            SDPWR_CMD_REFRESH: begin
                                if (st.open != 2'b00) next_st.illegal = 1'b1;
                                else begin
                                    // row comes from the counter, pins ignored
                                    next_st.row_cnt = st.row_cnt + 11'h001;
                                    next_st.wait_cnt = 4'(RC_CYC);
                                end
                            end
                            SDPWR_CMD_MODE_LOAD: begin
                                if (st.open != 2'b00) next_st.illegal = 1'b1;
                                else begin
                                    next_st.opcode = a;
                                    next_st.full_page = (a[2:0] == 3'h7);
                                    next_st.wait_cnt = 4'(MODE_LOAD_CYCLES);
                                end
                            end
                            default: ;
                        endcase
                    end
                    if (next_st.mode == st.mode)
                        next_st.mode = (next_st.open == 2'b00) ? SDPWR_M_IDLE : SDPWR_M_ACTIVE;
                end
                default: next_st.mode = SDPWR_M_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '{clk_prev: 1'b0, cke_prev: 1'b1, mode: SDPWR_M_IDLE, open: 2'b00,
                    autoclose: 2'b00, burst_cnt0: CNT_ZERO, burst_cnt1: CNT_ZERO,
                    rrd_cnt: CNT_ZERO, ras_cnt0: CNT_ZERO, ras_cnt1: CNT_ZERO,
                    wait_cnt: CNT_ZERO, full_page: 1'b0, opcode: OPCODE_RESET,
                    row_cnt: ROW_CNT_RESET, cmd_valid: 1'b0, cmd: SDPWR_CMD_DESELECT,
                    illegal: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign cmd_valid   = st.cmd_valid;
    assign cmd         = st.cmd;
    assign mode        = st.mode;
    assign bank_open   = st.open;
    assign opcode      = st.opcode;
    assign refresh_row = st.row_cnt;
    assign illegal     = st.illegal;
endmodule : sdpwr_mem
`default_nettype wire

// [hw/sdpwr_pkg.sv]
// shared constants and types for the dram command / clock-enable state block
package sdpwr_pkg;
    localparam int ADDR_W         = 12;
    localparam int BANK_SEL_BIT   = 11;
    localparam int OPCODE_W       = 12;
    localparam int ROW_W          = 11;
    localparam int CLK_DIV_HALF   = 4;
    localparam logic [2:0] DIV_RESET = 3'h0;
    localparam logic [11:0] OPCODE_RESET = 12'h000;
    localparam logic [10:0] ROW_CNT_RESET = 11'h000;
    // timing figures in ns (burst and mode load given in cycles), link clock cycles derived below
    localparam int LINK_PERIOD_NS     = 800;
    localparam int ROW_TO_ROW_DELAY_NS    = 20;
    localparam int MIN_ROW_ACTIVE_TIME_NS = 60;
    localparam int ROW_CYCLE_NS           = 90;
    localparam int BURST_CYCLES           = 4;
    localparam int MODE_LOAD_CYCLES       = 2;
    localparam int RRD_CYC = (ROW_TO_ROW_DELAY_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int RAS_CYC = (MIN_ROW_ACTIVE_TIME_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int RC_CYC  = (ROW_CYCLE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam logic [3:0] CNT_ZERO = 4'h0;

    typedef enum logic [3:0] {
        SDPWR_CMD_DESELECT,
        SDPWR_CMD_NOP,
        SDPWR_CMD_BURST_STOP,
        SDPWR_CMD_READ,
        SDPWR_CMD_READ_AUTOCLOSE,
        SDPWR_CMD_WRITE,
        SDPWR_CMD_WRITE_AUTOCLOSE,
        SDPWR_CMD_ROW_ACTIVATE,
        SDPWR_CMD_PRECHARGE,
        SDPWR_CMD_REFRESH,
        SDPWR_CMD_MODE_LOAD
    } sdpwr_cmd_t;

    typedef enum logic [2:0] {
        SDPWR_M_IDLE,
        SDPWR_M_ACTIVE,
        SDPWR_M_POWER_DOWN,
        SDPWR_M_SELF_REFRESH,
        SDPWR_M_SR_RECOVERY,
        SDPWR_M_SUSPEND
    } sdpwr_mode_t;
endpackage : sdpwr_pkg

// [hw/sdpwr_link_if.sv]
// pin-level link between the memory controller and the dram command end
`timescale 1ns/1ps
`default_nettype none
interface sdpwr_link_if;
    logic        link_clk;
    logic        clk_en;
    logic        chip_sel_n;
    logic        row_strobe_n;
    logic        col_strobe_n;
    logic        write_en_n;
    logic [11:0] addr;
    modport ctrl (output link_clk, output clk_en, output chip_sel_n, output row_strobe_n,
                  output col_strobe_n, output write_en_n, output addr);
    modport mem  (input link_clk, input clk_en, input chip_sel_n, input row_strobe_n,
                  input col_strobe_n, input write_en_n, input addr);
endinterface : sdpwr_link_if
`default_nettype wire

// [hw/sdpwr_sync.sv]
// two-flop synchroniser for pins sampled into sys_clk
`timescale 1ns/1ps
`default_nettype none
module sdpwr_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : sdpwr_sync
`default_nettype wire

// [hw/sdpwr_ctrl.sv]
// controller end: divides sys_clk into the link clock and drives one command per link cycle
`timescale 1ns/1ps
`default_nettype none
module sdpwr_ctrl (
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    sdpwr_link_if.ctrl                 link,
    input  wire logic                  req_valid,
    output logic                       req_ready,
    input  wire sdpwr_pkg::sdpwr_cmd_t req_cmd,
    input  wire logic [11:0]           req_addr,
    input  wire logic                  req_clk_en
);
    import sdpwr_pkg::*;

    typedef struct packed {
        logic [2:0]  div;
        logic        lclk;
        logic        cke;
        logic [3:0]  pins;
        logic [11:0] addr;
    } sdpwr_ctrl_st_t;

    sdpwr_ctrl_st_t st;
    sdpwr_ctrl_st_t next_st;
    logic           fall;

    always_comb begin
        next_st = st;
        fall    = 1'b0;
        next_st.div = st.div + 3'h1;
        if (st.div == 3'(CLK_DIV_HALF - 1)) begin
            next_st.div  = DIV_RESET;
            next_st.lclk = ~st.lclk;
            fall         = st.lclk;
        end
        // new pins set up on the falling edge, half a link period before the rise
        if (fall) begin
            next_st.cke  = req_valid ? req_clk_en : st.cke;
            next_st.addr = req_valid ? req_addr : st.addr;
            next_st.pins = 4'hF;
            if (req_valid) begin
                unique case (req_cmd)
                    SDPWR_CMD_DESELECT:        next_st.pins = 4'hF;
                    SDPWR_CMD_NOP:             next_st.pins = 4'h7;
                    SDPWR_CMD_BURST_STOP:      next_st.pins = 4'h6;
                    SDPWR_CMD_READ,
                    SDPWR_CMD_READ_AUTOCLOSE:  next_st.pins = 4'h5;
                    SDPWR_CMD_WRITE,
                    SDPWR_CMD_WRITE_AUTOCLOSE: next_st.pins = 4'h4;
                    SDPWR_CMD_ROW_ACTIVATE:    next_st.pins = 4'h3;
                    SDPWR_CMD_PRECHARGE:       next_st.pins = 4'h2;
                    SDPWR_CMD_REFRESH:         next_st.pins = 4'h1;
                    SDPWR_CMD_MODE_LOAD:       next_st.pins = 4'h0;
                    default:                   next_st.pins = 4'hF;
                endcase
                if (req_cmd == SDPWR_CMD_READ_AUTOCLOSE || req_cmd == SDPWR_CMD_WRITE_AUTOCLOSE)
                    next_st.addr[10] = 1'b1;
                else if (req_cmd == SDPWR_CMD_READ || req_cmd == SDPWR_CMD_WRITE)
                    next_st.addr[10] = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '{div: DIV_RESET, lclk: 1'b0, cke: 1'b1, pins: 4'hF, addr: OPCODE_RESET};
        end else begin
            st <= next_st;
        end
    end

    assign req_ready         = fall;
    assign link.link_clk     = st.lclk;
    assign link.clk_en       = st.cke;
    assign link.chip_sel_n   = st.pins[3];
    assign link.row_strobe_n = st.pins[2];
    assign link.col_strobe_n = st.pins[1];
    assign link.write_en_n   = st.pins[0];
    assign link.addr         = st.addr;
endmodule : sdpwr_ctrl
`default_nettype wire

// [testbench/sdpwr_checker.sv]
// concurrent checks on the link pins and on the dram end's decoded state
`timescale 1ns/1ps
`default_nettype none
module sdpwr_checker (
    input  wire logic                   sys_clk,
    input  wire logic                   reset_n,
    input  wire logic                   link_clk,
    input  wire logic                   clk_en,
    input  wire logic                   chip_sel_n,
    input  wire logic                   row_strobe_n,
    input  wire logic                   col_strobe_n,
    input  wire logic                   write_en_n,
    input  wire logic [11:0]            addr,
    input  wire logic                   cmd_valid,
    input  wire sdpwr_pkg::sdpwr_cmd_t  cmd,
    input  wire sdpwr_pkg::sdpwr_mode_t mode,
    input  wire logic [11:0]            opcode,
    input  wire logic                   illegal
);
    import sdpwr_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    logic [16:0] pins;
    // pins of the decoded command are still on the wire when the decoded state lands
    assign pins = {clk_en, chip_sel_n, row_strobe_n, col_strobe_n, write_en_n, addr};

    a_link_period: assert property ($rose(link_clk) |-> ##4 $fell(link_clk) ##4 $rose(link_clk))
        else $error("link clock period wrong");
    a_pins_hold: assert property (link_clk && $past(link_clk) |-> $stable(pins))
        else $error("link pins moved while link clock high");
    a_sample_delay: assert property (cmd_valid |-> $past(link_clk, 3) && !$past(link_clk, 4))
        else $error("command decoded off the link clock rise");
    a_opcode_capture: assert property (cmd_valid && cmd == SDPWR_CMD_MODE_LOAD && !illegal
        && mode == SDPWR_M_IDLE |-> opcode == $past(addr, 2))
        else $error("mode load opcode differs from address");
    a_opcode_hold: assert property ($changed(opcode) |-> cmd_valid && cmd == SDPWR_CMD_MODE_LOAD)
        else $error("opcode changed without mode load");
    a_sr_entry: assert property ($changed(mode) && mode == SDPWR_M_SELF_REFRESH
        |-> $past(mode) == SDPWR_M_IDLE && !clk_en && pins[15:12] == 4'h1)
        else $error("self-refresh entered wrongly");
    a_pd_entry: assert property ($changed(mode) && mode == SDPWR_M_POWER_DOWN |-> !clk_en
        && ($past(mode) == SDPWR_M_IDLE || $past(mode) == SDPWR_M_SR_RECOVERY))
        else $error("power-down entered wrongly");
    a_pd_exit: assert property ($past(mode) == SDPWR_M_POWER_DOWN
        && mode != SDPWR_M_POWER_DOWN |-> mode == SDPWR_M_IDLE && clk_en)
        else $error("power-down left wrongly");
    a_sr_exit: assert property ($past(mode) == SDPWR_M_SELF_REFRESH
        && mode != SDPWR_M_SELF_REFRESH |-> mode == SDPWR_M_SR_RECOVERY && clk_en)
        else $error("self-refresh left wrongly");
    a_suspend_entry: assert property ($changed(mode) && mode == SDPWR_M_SUSPEND
        |-> !clk_en && $past(mode) == SDPWR_M_ACTIVE)
        else $error("suspend entered wrongly");
    a_suspend_exit: assert property ($past(mode) == SDPWR_M_SUSPEND
        && mode != SDPWR_M_SUSPEND |-> clk_en && mode == SDPWR_M_ACTIVE)
        else $error("suspend left wrongly");

    c_mode_load: cover property (cmd_valid && cmd == SDPWR_CMD_MODE_LOAD);
    c_suspend: cover property (mode == SDPWR_M_SUSPEND);
    c_power_down: cover property (mode == SDPWR_M_POWER_DOWN);
    c_recovery: cover property (mode == SDPWR_M_SR_RECOVERY);
endmodule // sdpwr_checker
`default_nettype wire

// [testbench/sdpwr_cke_power_state_control_test.sv]
// self-checking bench: controller end drives the dram end across the link
`timescale 1ns/1ps
`default_nettype none
module sdpwr_cke_power_state_control_test;
    import sdpwr_pkg::*;
    logic        sys_clk    = 1'b0;
    logic        reset_n    = 1'b0;
    logic        req_valid  = 1'b0;
    logic        req_ready;
    sdpwr_cmd_t  req_cmd    = SDPWR_CMD_NOP;
    logic [11:0] req_addr   = 12'h000;
    logic        req_clk_en = 1'b1;
    logic        cmd_valid;
    sdpwr_cmd_t  cmd;
    sdpwr_mode_t mode;
    logic [1:0]  bank_open;
    logic [11:0] opcode;
    logic [10:0] refresh_row;
    logic        illegal;
    logic        ill_seen   = 1'b0;
    int          err_total  = 0;
    int          checks     = 0;

    sdpwr_link_if link_bus ();
    always #50 sys_clk = ~sys_clk;

    sdpwr_ctrl sdpwr_ctrl_inst (.sys_clk(sys_clk), .reset_n(reset_n), .link(link_bus.ctrl),
        .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
        .req_addr(req_addr), .req_clk_en(req_clk_en));
    sdpwr_mem sdpwr_mem_inst (.sys_clk(sys_clk), .reset_n(reset_n), .link(link_bus.mem),
        .cmd_valid(cmd_valid), .cmd(cmd), .mode(mode), .bank_open(bank_open),
        .opcode(opcode), .refresh_row(refresh_row), .illegal(illegal));
    sdpwr_checker sdpwr_checker_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .link_clk(link_bus.link_clk), .clk_en(link_bus.clk_en),
        .chip_sel_n(link_bus.chip_sel_n), .row_strobe_n(link_bus.row_strobe_n),
        .col_strobe_n(link_bus.col_strobe_n), .write_en_n(link_bus.write_en_n),
        .addr(link_bus.addr), .cmd_valid(cmd_valid), .cmd(cmd), .mode(mode),
        .opcode(opcode), .illegal(illegal));

    task automatic cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // valid stays high: between requests the controller sends no-ops at the held enable level,
    // so the clock enable never falls back to a default behind our back
    task automatic op(input sdpwr_cmd_t c, input logic [11:0] a, input logic k);
        int n;
        n = 0;
        req_cmd = c;
        req_addr = a;
        req_clk_en = k;
        while (req_ready !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n == 40) begin
            cmp("request taken", 12'h001, 12'h000);
        end
        @(posedge sys_clk);
        #1;
        req_cmd = SDPWR_CMD_NOP;
        ill_seen = 1'b0;
        // returning before the next take keeps calls one link cycle apart
        repeat (7) begin
            @(posedge sys_clk);
            #1;
            ill_seen = ill_seen | illegal;
        end
    endtask

    task automatic chk(input sdpwr_mode_t m, input logic il);
        cmp("mode", 12'(m), 12'(mode));
        cmp("illegal", 12'(il), 12'(ill_seen));
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge sys_clk);
        err_total++;
        give_verdict();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        req_valid = 1'b1;
        chk(SDPWR_M_IDLE, 1'b0);
        cmp("opcode", 12'h000, opcode);
        cmp("row", 12'h000, 12'(refresh_row));
        op(SDPWR_CMD_MODE_LOAD, 12'h0a37, 1'b1);
        chk(SDPWR_M_IDLE, 1'b0);
        cmp("opcode", 12'h0a37, opcode);
        repeat (16) @(posedge sys_clk);
        #1;
        op(SDPWR_CMD_REFRESH, 12'h0fff, 1'b1);
        chk(SDPWR_M_IDLE, 1'b0);
        cmp("row", 12'h001, 12'(refresh_row));
        repeat (16) @(posedge sys_clk);
        #1;
        op(SDPWR_CMD_ROW_ACTIVATE, 12'h800, 1'b1);
        chk(SDPWR_M_ACTIVE, 1'b0);
        cmp("banks", 12'h002, 12'(bank_open));
        // the other bank one link cycle later: row-to-row delay already met
        op(SDPWR_CMD_ROW_ACTIVATE, 12'h000, 1'b1);
        chk(SDPWR_M_ACTIVE, 1'b0);
        cmp("banks", 12'h003, 12'(bank_open));
        op(SDPWR_CMD_ROW_ACTIVATE, 12'h800, 1'b1);
        chk(SDPWR_M_ACTIVE, 1'b1);
        op(SDPWR_CMD_READ, 12'h800, 1'b1);
        chk(SDPWR_M_ACTIVE, 1'b0);
        op(SDPWR_CMD_BURST_STOP, 12'h000, 1'b1);
        chk(SDPWR_M_ACTIVE, 1'b0);
        op(SDPWR_CMD_NOP, 12'h000, 1'b0);
        chk(SDPWR_M_SUSPEND, 1'b0);
        op(SDPWR_CMD_NOP, 12'h000, 1'b1);
        chk(SDPWR_M_ACTIVE, 1'b0);
        op(SDPWR_CMD_PRECHARGE, 12'h400, 1'b1);
        chk(SDPWR_M_IDLE, 1'b0);
        cmp("banks", 12'h000, 12'(bank_open));
        op(SDPWR_CMD_WRITE, 12'h000, 1'b1);
        chk(SDPWR_M_IDLE, 1'b1);
        op(SDPWR_CMD_NOP, 12'h000, 1'b0);
        chk(SDPWR_M_POWER_DOWN, 1'b0);
        op(SDPWR_CMD_MODE_LOAD, 12'h0123, 1'b0);
        chk(SDPWR_M_POWER_DOWN, 1'b0);
        cmp("opcode", 12'h0a37, opcode);
        op(SDPWR_CMD_NOP, 12'h000, 1'b1);
        chk(SDPWR_M_IDLE, 1'b0);
        op(SDPWR_CMD_REFRESH, 12'h000, 1'b0);
        chk(SDPWR_M_SELF_REFRESH, 1'b0);
        op(SDPWR_CMD_MODE_LOAD, 12'h0456, 1'b0);
        chk(SDPWR_M_SELF_REFRESH, 1'b0);
        cmp("opcode", 12'h0a37, opcode);
        op(SDPWR_CMD_NOP, 12'h000, 1'b1);
        chk(SDPWR_M_SR_RECOVERY, 1'b0);
        // recovery lasts one link cycle, so this drop must land inside it
        op(SDPWR_CMD_NOP, 12'h000, 1'b0);
        chk(SDPWR_M_POWER_DOWN, 1'b0);
        op(SDPWR_CMD_NOP, 12'h000, 1'b1);
        chk(SDPWR_M_IDLE, 1'b0);
        op(SDPWR_CMD_ROW_ACTIVATE, 12'h000, 1'b1);
        op(SDPWR_CMD_READ_AUTOCLOSE, 12'h400, 1'b1);
        chk(SDPWR_M_ACTIVE, 1'b0);
        // four link cycles of burst, then the bank must close by itself
        repeat (48) @(posedge sys_clk);
        #1;
        cmp("banks", 12'h000, 12'(bank_open));
        give_verdict();
    end
endmodule // sdpwr_cke_power_state_control_test
`default_nettype wire
